// ==== core/panel_keypad_menu_controller.sv ====
`timescale 1ns/1ps
module panel_keypad_menu_controller import panel_pkg::*;
#(
  parameter int DB_CYC = DEBOUNCE_CYC,
  parameter int HOLD = HOLD_CYC,
  parameter int START = REPEAT_START_CYC,
  parameter int SLOW = REPEAT_SLOW_CYC,
  parameter int FAST = REPEAT_FAST_CYC,
  parameter int BLINK = BLINK_CYC
)
(
  input wire logic core_clk, // System clock, 25 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire keys_t key_raw, // Front key pins, high while pressed.
  input wire logic [2:0] user_raw, // User input pins.
  input wire logic sourcing_jumper, // Logic jumper pin, high for sourcing.
  input wire logic user1_lock_en, // User input 1 acts as program lock.
  input wire logic [15:0] lock_code, // Programmed security code.
  input wire logic quick_only, // Enter quick instead of full programming.
  input wire logic [NPAR-1:0] quick_mask, // Parameters offered in quick mode.
  input wire logic [2:0] card_present, // Option cards for modules 6 to 8.
  input wire annun_t hide, // Readout lockouts for the display cycle.
  input wire logic up_fn_en, // Up function key has a function.
  input wire logic down_fn_en, // Down function key has a function.
  input wire logic rst_fn_en, // Reset function key has a function.
  input wire logic [IDX_W-1:0] rd_index, // Parameter read index.
  output logic [1:0] view, // Reading shown in display mode.
  output annun_t annun, // Annunciators.
  output logic prog_active, // Any programming mode.
  output logic full_prog, // Full programming, measurement suspended.
  output logic quick_prog, // Quick programming.
  output logic show_prompt, // Prompt phase of the alternating display.
  output logic [3:0] cur_module, // Selected module.
  output logic [1:0] cur_param, // Parameter within module.
  output logic [VAL_W-1:0] edit_value, // Value or selection being edited.
  output fn_t fn_pulse, // Function key pulses.
  output logic entry_refused, // Pulse: programming entry refused.
  output logic commit_pulse, // Pulse: write changes to non-volatile store.
  output logic restored, // Pulse: defaults restored.
  output logic [2:0] user_active, // Qualified user inputs.
  output logic [VAL_W-1:0] rd_data // Stored parameter at rd_index.
);
  typedef enum logic [2:0] {
    M_DISP = 3'b001,
    M_MOD = 3'b010,
    M_PAR = 3'b100
  } mode_t;

  typedef struct packed {
    mode_t mode;
    logic quick;
    logic [1:0] view;
    annun_t annun;
    logic [3:0] modnum;
    logic [1:0] pidx;
    logic [VAL_W-1:0] work;
    logic [NPAR-1:0][VAL_W-1:0] store;
    logic dirty;
    logic commit;
    logic refuse;
    logic restored;
    fn_t fn;
    logic [2:0] u1;
    logic [2:0] u2;
    logic j1;
    logic j2;
    logic [2:0] uact;
    logic prompt;
    logic [$clog2(BLINK+1)-1:0] bcnt;
    logic [VAL_W-1:0] rd;
  } st_t;

  st_t q;
  st_t n;
  keys_t kl;
  keys_t kp;
  logic [4:0] kl_v;
  logic [4:0] kp_v;
  logic up_step;
  logic up_long;
  logic up_short;
  logic dn_step;
  logic dn_long;
  logic dn_short;
  logic locked;
  logic code_nz;
  logic [IDX_W-1:0] gi;
  logic [2:0] nxt;

  function automatic logic [IDX_W-1:0] gidx(input logic [3:0] m, input logic [1:0] i);
    return IDX_W'(m * PAR_PER_MOD + i);
  endfunction

  function automatic logic mod_ok(input logic [3:0] m, input logic [2:0] cards);
    logic ok;
    ok = 1'b1;
    if (m >= MOD_CARD_FIRST && m <= MOD_CARD_LAST)
      ok = cards[2'(m - MOD_CARD_FIRST)];
    return ok;
  endfunction

  // Walks to the next selectable module, wrapping, skipping absent cards.
  function automatic logic [3:0] step_mod(input logic [3:0] m, input logic up, input logic [2:0] cards);
    logic [3:0] c;
    logic done;
    c = m;
    done = 1'b0;
    for (int i = 0; i < NUM_MOD; i++)
    begin
      if (!done)
      begin
        if (up)
          c = (c == MOD_LAST) ? 4'h0 : c + 4'h1;
        else
          c = (c == 4'h0) ? MOD_LAST : c - 4'h1;
        done = mod_ok(c, cards);
      end
    end
    return c;
  endfunction

  // Returns found flag and index of the first offered parameter at or after from.
  function automatic logic [2:0] next_param(input logic [3:0] m, input logic [2:0] from, input logic quick,
                                            input logic [NPAR-1:0] mask, input logic cnz);
    logic [2:0] r;
    logic [IDX_W-1:0] g;
    r = '0;
    for (int i = 0; i < PAR_PER_MOD; i++)
    begin
      g = gidx(m, 2'(i));
      if (!r[2] && 3'(i) >= from)
      begin
        if (!quick || (mask[g] && (g != INTENSITY_IDX || cnz)))
          r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] next_view(input logic [1:0] v, input annun_t h);
    logic [1:0] c;
    logic done;
    c = v;
    done = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (!done)
      begin
        c = c + 2'h1;
        done = (c == VIEW_INPUT) || !((c == VIEW_PEAK && h.peak) || (c == VIEW_VALLEY && h.valley) ||
               (c == VIEW_TOTAL && h.total));
      end
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  genvar gk;
  generate
    for (gk = 0; gk < 5; gk++)
    begin : g_key
      key_debounce #(.CNT(DB_CYC)) u_db (
        .core_clk(core_clk),
        .rst(rst),
        .raw(key_raw[gk]),
        .level(kl_v[gk]),
        .press(kp_v[gk])
      );
    end
  endgenerate

  assign kl = kl_v;
  assign kp = kp_v;

  arrow_repeat #(.HOLD(HOLD), .START(START), .SLOW(SLOW), .FAST(FAST)) u_up (
    .core_clk(core_clk),
    .rst(rst),
    .level(kl.up),
    .press(kp.up),
    .step(up_step),
    .long_hold(up_long),
    .short_rel(up_short)
  );

  arrow_repeat #(.HOLD(HOLD), .START(START), .SLOW(SLOW), .FAST(FAST)) u_dn (
    .core_clk(core_clk),
    .rst(rst),
    .level(kl.down),
    .press(kp.down),
    .step(dn_step),
    .long_hold(dn_long),
    .short_rel(dn_short)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign code_nz = (lock_code != 16'h0000);
  assign locked = code_nz || (user1_lock_en && q.uact[0]);
  assign gi = gidx(q.modnum, q.pidx);
  assign nxt = next_param(q.modnum, 3'(q.pidx) + 3'h1, q.quick, quick_mask, code_nz);

  always_comb
  begin
    logic [VAL_W-1:0] amt;
    logic [2:0] first;
    amt = kl.rst ? BIG_STEP : 17'h0_0001;
    first = next_param(q.modnum, 3'h0, q.quick, quick_mask, code_nz);
    n = q;
    n.commit = 1'b0;
    n.refuse = 1'b0;
    n.restored = 1'b0;
    n.fn = '0;
    n.u1 = user_raw;
    n.u2 = q.u1;
    n.j1 = sourcing_jumper;
    n.j2 = q.j1;
    // Sinking inputs assert low, sourcing inputs high; ignored in full programming.
    n.uact = (q.j2 ? q.u2 : ~q.u2) & {3{!(q.mode != M_DISP && !q.quick)}};
    n.rd = (rd_index < IDX_W'(NPAR)) ? q.store[rd_index] : PARAM_DEFAULT;
    if (q.bcnt == $bits(q.bcnt)'(BLINK - 1))
    begin
      n.bcnt = '0;
      n.prompt = !q.prompt;
    end
    else
      n.bcnt = q.bcnt + 1'b1;
    unique case (q.mode)
      M_DISP:
      begin
        if (kp.dsp)
          n.view = next_view(q.view, hide);
        n.fn.rst = kp.rst && rst_fn_en;
        n.fn.up1 = up_short && up_fn_en;
        n.fn.up2 = up_long && up_fn_en;
        n.fn.down1 = dn_short && down_fn_en;
        n.fn.down2 = dn_long && down_fn_en;
        if (kp.par)
        begin
          if (locked)
            n.refuse = 1'b1;
          else
          begin
            n.mode = M_MOD;
            n.modnum = 4'h0;
            n.quick = quick_only;
            n.dirty = 1'b0;
            n.prompt = 1'b1;
            n.bcnt = '0;
          end
        end
      end
      M_MOD:
      begin
        if (kp.dsp || (kp.par && q.modnum == 4'h0))
        begin
          n.mode = M_DISP;
          n.commit = q.dirty;
          n.dirty = 1'b0;
        end
        else if (kp.par)
        begin
          if (first[2])
          begin
            n.mode = M_PAR;
            n.pidx = first[1:0];
            n.work = q.store[gidx(q.modnum, first[1:0])];
          end
        end
        else if (up_step)
          n.modnum = step_mod(q.modnum, 1'b1, card_present);
        else if (dn_step)
          n.modnum = step_mod(q.modnum, 1'b0, card_present);
      end
      M_PAR:
      begin
        if (kp.dsp)
        begin
          n.mode = M_DISP;
          n.commit = q.dirty;
          n.dirty = 1'b0;
        end
        else if (kp.par)
        begin
          n.dirty = 1'b1;
          if (gi == RESTORE_IDX && q.work != PARAM_DEFAULT)
          begin
            n.store = {NPAR{PARAM_DEFAULT}};
            n.restored = 1'b1;
          end
          else
            n.store[gi] = q.work;
          if (nxt[2])
          begin
            n.pidx = nxt[1:0];
            n.work = n.store[gidx(q.modnum, nxt[1:0])];
          end
          else
            n.mode = M_MOD;
        end
        else if (up_step)
        begin
          if (NUMERIC_MASK[gi])
            n.work = (q.work > NUM_MAX - amt) ? NUM_MAX : q.work + amt;
          else
            n.work = (q.work >= LIST_MAX) ? PARAM_DEFAULT : q.work + 17'h0_0001;
        end
        else if (dn_step)
        begin
          if (NUMERIC_MASK[gi])
            n.work = (q.work < amt) ? PARAM_DEFAULT : q.work - amt;
          else
            n.work = (q.work == PARAM_DEFAULT) ? LIST_MAX : q.work - 17'h0_0001;
        end
      end
      default:
        n.mode = M_DISP;
    endcase
    n.annun.peak = (n.view == VIEW_PEAK);
    n.annun.valley = (n.view == VIEW_VALLEY);
    n.annun.total = (n.view == VIEW_TOTAL);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.mode <= M_DISP;
      q.view <= VIEW_INPUT;
      q.store <= {NPAR{PARAM_DEFAULT}};
    end
    else
      q <= n;
  end

  assign view = q.view;
  assign annun = q.annun;
  assign prog_active = (q.mode != M_DISP);
  assign full_prog = (q.mode != M_DISP) && !q.quick;
  assign quick_prog = (q.mode != M_DISP) && q.quick;
  assign show_prompt = q.prompt;
  assign cur_module = q.modnum;
  assign cur_param = q.pidx;
  assign edit_value = q.work;
  assign fn_pulse = q.fn;
  assign entry_refused = q.refuse;
  assign commit_pulse = q.commit;
  assign restored = q.restored;
  assign user_active = q.uact;
  assign rd_data = q.rd;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_view_adv;
    (q.mode == M_DISP && kp.dsp && hide == '0) |=> (view == $past(view) + 2'h1);
  endproperty
  a_view_adv: assert property (p_view_adv) else $error("display key did not advance view");
  property p_annun;
    (view == VIEW_INPUT) |-> (annun == '0);
  endproperty
  a_annun: assert property (p_annun) else $error("annunciator lit on input view");
  property p_refuse;
    (q.mode == M_DISP && kp.par && code_nz) |=> (q.mode == M_DISP && entry_refused);
  endproperty
  a_refuse: assert property (p_refuse) else $error("locked entry not refused");
  property p_enter;
    (q.mode == M_DISP && kp.par && !locked) |=> (q.mode == M_MOD && cur_module == 4'h0);
  endproperty
  a_enter: assert property (p_enter) else $error("entry not at module zero");
  property p_last_param;
    (q.mode == M_PAR && kp.par && !kp.dsp && q.pidx == 2'h3) |=> (q.mode == M_MOD);
  endproperty
  a_last_param: assert property (p_last_param) else $error("no return after last parameter");
  property p_big_step;
    (q.mode == M_PAR && NUMERIC_MASK[gi] && up_step && !kp.dsp && !kp.par && kl.rst && edit_value < NUM_MAX - BIG_STEP)
      |=> (edit_value == $past(edit_value) + BIG_STEP);
  endproperty
  a_big_step: assert property (p_big_step) else $error("reset plus arrow not by thousand");
  property p_exit;
    (q.mode != M_DISP && kp.dsp) |=> (q.mode == M_DISP && commit_pulse == $past(q.dirty));
  endproperty
  a_exit: assert property (p_exit) else $error("display key exit or commit wrong");
  property p_full_users;
    $past(full_prog) |-> (user_active == 3'h0);
  endproperty
  a_full_users: assert property (p_full_users) else $error("user input active in full mode");
  property p_quick;
    (q.mode == M_DISP && kp.par && !locked && quick_only) |=> (quick_prog && !full_prog);
  endproperty
  a_quick: assert property (p_quick) else $error("quick mode not entered");
  property p_card;
    (q.mode == M_MOD && $past(q.mode) == M_MOD && $changed(cur_module) && cur_module >= MOD_CARD_FIRST &&
      cur_module <= MOD_CARD_LAST) |-> (($past(card_present) >> (cur_module - MOD_CARD_FIRST)) & 3'h1) != 3'h0;
  endproperty
  a_card: assert property (p_card) else $error("card module selected without card");
endmodule

// ==== inc/panel_pkg.sv ====
// Functional notes
// - Display key cycles peak, valley, total, input.
// - Annunciator names peak, valley, total; input none.
// - Locked-out readouts are skipped in cycle.
// - Arrow held three seconds gives second function.
// - Disabled function keys do nothing in display.
// - Parameter key enters programming unless locked.
// - Programming opens at module zero; arrows select.
// - Parameter key steps parameters, then back.
// - List parameter: arrows step, parameter key stores.
// - Numeric arrows step, auto-repeat speeds up.
// - Reset key with arrow steps by thousand.
// - Display key or module-zero exit commits changes.
// - Full mode shows all, user inputs suspended.
// - Quick mode offers configured subset only.
// - Intensity offered in quick only with code.
// - Modules six to eight need option card.
// - Module nine restores all default values.
package panel_pkg;
  localparam int CLK_KHZ = 25000;
  localparam int DEBOUNCE_MS = 20;
  localparam int HOLD_MS = 3000;
  localparam int REPEAT_START_MS = 500;
  localparam int REPEAT_SLOW_MS = 200;
  localparam int REPEAT_FAST_MS = 25;
  localparam int BLINK_MS = 500;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
  localparam int REPEAT_START_CYC = REPEAT_START_MS * CLK_KHZ;
  localparam int REPEAT_SLOW_CYC = REPEAT_SLOW_MS * CLK_KHZ;
  localparam int REPEAT_FAST_CYC = REPEAT_FAST_MS * CLK_KHZ;
  localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
  localparam int NUM_MOD = 10;
  localparam int PAR_PER_MOD = 4;
  localparam int NPAR = NUM_MOD * PAR_PER_MOD;
  localparam int VAL_W = 17;
  localparam int IDX_W = 6;
  localparam logic [VAL_W-1:0] NUM_MAX = 17'h1_869F;
  localparam logic [VAL_W-1:0] BIG_STEP = 17'h0_03E8;
  localparam logic [VAL_W-1:0] LIST_MAX = 17'h0_0007;
  localparam logic [VAL_W-1:0] PARAM_DEFAULT = 17'h0_0000;
  localparam logic [NPAR-1:0] NUMERIC_MASK = 40'h00_CCCC_CCCC;
  localparam logic [3:0] MOD_LAST = 4'h9;
  localparam logic [3:0] MOD_CARD_FIRST = 4'h6;
  localparam logic [3:0] MOD_CARD_LAST = 4'h8;
  localparam logic [IDX_W-1:0] RESTORE_IDX = 6'h24;
  localparam logic [IDX_W-1:0] INTENSITY_IDX = 6'h25;
  localparam logic [1:0] VIEW_PEAK = 2'h0;
  localparam logic [1:0] VIEW_VALLEY = 2'h1;
  localparam logic [1:0] VIEW_TOTAL = 2'h2;
  localparam logic [1:0] VIEW_INPUT = 2'h3;
  typedef struct packed {
    logic dsp;
    logic par;
    logic up;
    logic down;
    logic rst;
  } keys_t;
  typedef struct packed {
    logic peak;
    logic valley;
    logic total;
  } annun_t;
  typedef struct packed {
    logic up1;
    logic up2;
    logic down1;
    logic down2;
    logic rst;
  } fn_t;
endpackage

// ==== core/key_debounce.sv ====
`timescale 1ns/1ps
module key_debounce import panel_pkg::*;
#(
  parameter int CNT = DEBOUNCE_CYC
)
(
  input wire logic core_clk, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic raw, // Key pin, high while pressed.
  output logic level, // Debounced key level.
  output logic press // One-cycle pulse per press.
);
  localparam int CW = $clog2(CNT + 1);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic prs;
    logic [CW-1:0] cnt;
  } db_t;
  db_t q;
  db_t n;

  // The level changes only after the pin has held its new value for CNT cycles.
  always_comb
  begin
    n = q;
    n.s1 = raw;
    n.s2 = q.s1;
    n.prs = 1'b0;
    if (q.s2 == q.lvl)
      n.cnt = '0;
    else if (q.cnt == CW'(CNT - 1))
    begin
      n.lvl = q.s2;
      n.prs = q.s2;
      n.cnt = '0;
    end
    else
      n.cnt = q.cnt + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end

  assign level = q.lvl;
  assign press = q.prs;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_one_press;
    press |-> level ##1 !press;
  endproperty
  a_one_press: assert property (p_one_press) else $error("press pulse not single");
endmodule

// ==== core/arrow_repeat.sv ====
`timescale 1ns/1ps
module arrow_repeat import panel_pkg::*;
#(
  parameter int HOLD = HOLD_CYC,
  parameter int START = REPEAT_START_CYC,
  parameter int SLOW = REPEAT_SLOW_CYC,
  parameter int FAST = REPEAT_FAST_CYC
)
(
  input wire logic core_clk, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic level, // Debounced arrow level.
  input wire logic press, // Debounced press pulse.
  output logic step, // Value step pulse, press and auto-repeat.
  output logic long_hold, // Pulse when held for HOLD cycles.
  output logic short_rel // Pulse on release before HOLD.
);
  localparam int HW = $clog2(HOLD + START + 1);
  typedef struct packed {
    logic held;
    logic fired;
    logic [HW-1:0] cnt;
    logic [HW-1:0] rcnt;
    logic [HW-1:0] period;
    logic [2:0] nrep;
    logic step;
    logic lng;
    logic shrt;
  } rp_t;
  rp_t q;
  rp_t n;

  always_comb
  begin
    n = q;
    n.step = 1'b0;
    n.lng = 1'b0;
    n.shrt = 1'b0;
    if (press)
    begin
      n.held = 1'b1;
      n.fired = 1'b0;
      n.step = 1'b1;
      n.cnt = '0;
      n.rcnt = '0;
      n.period = HW'(SLOW);
      n.nrep = '0;
    end
    else if (q.held && !level)
    begin
      n.held = 1'b0;
      n.shrt = !q.fired;
    end
    else if (q.held)
    begin
      if (q.cnt != HW'(HOLD + START))
        n.cnt = q.cnt + 1'b1;
      if (q.cnt == HW'(HOLD - 1) && !q.fired)
      begin
        n.lng = 1'b1;
        n.fired = 1'b1;
      end
      // Repeats begin after START and speed up every eight steps.
      if (q.cnt >= HW'(START))
      begin
        if (q.rcnt >= q.period - 1'b1)
        begin
          n.step = 1'b1;
          n.rcnt = '0;
          n.nrep = q.nrep + 1'b1;
          if (q.nrep == 3'h7 && q.period > HW'(2 * FAST))
            n.period = q.period >> 1;
        end
        else
          n.rcnt = q.rcnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end

  assign step = q.step;
  assign long_hold = q.lng;
  assign short_rel = q.shrt;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_step_on_press;
    press |=> step;
  endproperty
  a_step_on_press: assert property (p_step_on_press) else $error("press gave no step");
  property p_long_not_short;
    long_hold |-> !short_rel ##1 !long_hold;
  endproperty
  a_long_not_short: assert property (p_long_not_short) else $error("long hold pulse wrong");
endmodule

// ==== bench/key_operator.sv ====
`timescale 1ns/1ps
module key_operator import panel_pkg::*;
(
  input wire logic core_clk, // System clock.
  output keys_t key_raw // Key pins, high while pressed.
);
  initial key_raw = '0;
  // A press stays steady well past the debounce span, and so does the release after it.
  task automatic tap(input keys_t k, input int n);
    @(negedge core_clk);
    key_raw = key_raw | k;
    repeat (n) @(negedge core_clk);
    key_raw = key_raw & ~k;
    repeat (12) @(negedge core_clk);
  endtask
  task automatic hold(input keys_t k, input logic on);
    @(negedge core_clk);
    key_raw = on ? (key_raw | k) : (key_raw & ~k);
    repeat (12) @(negedge core_clk);
  endtask
endmodule

// ==== bench/panel_keypad_menu_controller_bench.sv ====
`timescale 1ns/1ps
module panel_keypad_menu_controller_bench import panel_pkg::*;
;
  localparam keys_t K_DSP = 5'h10;
  localparam keys_t K_PAR = 5'h08;
  localparam keys_t K_UP = 5'h04;
  localparam keys_t K_DOWN = 5'h02;
  localparam keys_t K_RST = 5'h01;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  keys_t key_raw;
  logic [2:0] user_raw = 3'h0;
  logic sourcing_jumper = 1'b1, user1_lock_en = 1'b0, quick_only = 1'b0, up_fn_en = 1'b0;
  logic down_fn_en = 1'b0, rst_fn_en = 1'b0;
  logic [15:0] lock_code = 16'h0000;
  logic [NPAR-1:0] quick_mask = '0;
  logic [2:0] card_present = 3'h0;
  annun_t hide = '0;
  logic [IDX_W-1:0] rd_index = 6'h00;
  logic [1:0] view, cur_param;
  annun_t annun;
  logic prog_active, full_prog, quick_prog, show_prompt, entry_refused, commit_pulse, restored;
  logic [3:0] cur_module;
  logic [VAL_W-1:0] edit_value, rd_data;
  fn_t fn_pulse;
  logic [2:0] user_active;
  int errors = 0, n_tests = 0, n_commit = 0, n_refuse = 0, n_restore = 0, n_up1 = 0, n_up2 = 0;
  int n_dn1 = 0, n_rst = 0;
  always #20 core_clk = ~core_clk;
  key_operator key_operator_i (.core_clk(core_clk), .key_raw(key_raw));
  panel_keypad_menu_controller #(.DB_CYC(4), .HOLD(200), .START(40), .SLOW(16), .FAST(2), .BLINK(8))
  panel_keypad_menu_controller_i (.core_clk(core_clk), .rst(rst), .key_raw(key_raw), .user_raw(user_raw),
    .sourcing_jumper(sourcing_jumper), .user1_lock_en(user1_lock_en), .lock_code(lock_code),
    .quick_only(quick_only), .quick_mask(quick_mask), .card_present(card_present), .hide(hide),
    .up_fn_en(up_fn_en), .down_fn_en(down_fn_en), .rst_fn_en(rst_fn_en), .rd_index(rd_index), .view(view),
    .annun(annun), .prog_active(prog_active), .full_prog(full_prog), .quick_prog(quick_prog),
    .show_prompt(show_prompt), .cur_module(cur_module), .cur_param(cur_param), .edit_value(edit_value),
    .fn_pulse(fn_pulse), .entry_refused(entry_refused), .commit_pulse(commit_pulse), .restored(restored),
    .user_active(user_active), .rd_data(rd_data));
  // Pulses are counted here so that no check has to land on their single cycle.
  always @(negedge core_clk)
  begin
    if (fn_pulse.down1 === 1'b1) n_dn1++;
    if (fn_pulse.rst === 1'b1) n_rst++;
    if (commit_pulse === 1'b1) n_commit++;
    if (entry_refused === 1'b1) n_refuse++;
    if (restored === 1'b1) n_restore++;
    if (fn_pulse.up1 === 1'b1) n_up1++;
    if (fn_pulse.up2 === 1'b1) n_up2++;
  end
  task automatic check(input string name, input logic [VAL_W-1:0] exp, input logic [VAL_W-1:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic stop_test;
    $display("errors %0d, checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    settle(20);
    rst = 1'b0;
    settle(4);
    check("view", 17'(VIEW_INPUT), 17'(view));
    check("annun", 17'h0_0000, 17'(annun));
    check("prompt", 17'h0_0000, 17'(show_prompt));
    settle(4);
    check("prompt", 17'h0_0001, 17'(show_prompt));
    for (int i = 0; i < 4; i++)
    begin
      key_operator_i.tap(K_DSP, 10);
      check("view", 17'(i), 17'(view));
      check("annun", (i < 3) ? 17'(3'b100 >> i) : 17'h0_0000, 17'(annun));
    end
    hide.valley = 1'b1;
    key_operator_i.tap(K_DSP, 10);
    key_operator_i.tap(K_DSP, 10);
    check("view", 17'(VIEW_TOTAL), 17'(view));
    key_operator_i.tap(K_UP, 10);
    check("up1", 17'h0_0000, 17'(n_up1));
    check("view", 17'(VIEW_TOTAL), 17'(view));
    up_fn_en = 1'b1;
    key_operator_i.tap(K_UP, 10);
    check("up1", 17'h0_0001, 17'(n_up1));
    key_operator_i.tap(K_UP, 230);
    check("up2", 17'h0_0001, 17'(n_up2));
    check("up1", 17'h0_0001, 17'(n_up1));
    key_operator_i.tap(K_DOWN | K_RST, 10);
    check("fn", 17'h0_0000, 17'(n_dn1 + n_rst));
    down_fn_en = 1'b1;
    rst_fn_en = 1'b1;
    key_operator_i.tap(K_DOWN | K_RST, 10);
    check("down1", 17'h0_0001, 17'(n_dn1));
    check("rst fn", 17'h0_0001, 17'(n_rst));
    down_fn_en = 1'b0;
    rst_fn_en = 1'b0;
    up_fn_en = 1'b0;
    lock_code = 16'h0001;
    key_operator_i.tap(K_PAR, 10);
    check("refused", 17'h0_0001, 17'(n_refuse));
    check("prog", 17'h0_0000, 17'(prog_active));
    lock_code = 16'h0000;
    user1_lock_en = 1'b1;
    user_raw = 3'b001;
    settle(6);
    check("user", 17'h0_0001, 17'(user_active));
    key_operator_i.tap(K_PAR, 10);
    check("refused", 17'h0_0002, 17'(n_refuse));
    sourcing_jumper = 1'b0;
    user_raw = 3'b110;
    settle(6);
    check("user", 17'h0_0001, 17'(user_active));
    user_raw = 3'b111;
    settle(6);
    check("user", 17'h0_0000, 17'(user_active));
    key_operator_i.tap(K_PAR, 10);
    check("prog", 17'h0_0001, 17'(prog_active));
    check("full", 17'h0_0001, 17'(full_prog));
    check("module", 17'h0_0000, 17'(cur_module));
    user_raw = 3'b000;
    settle(6);
    check("user", 17'h0_0000, 17'(user_active));
    user1_lock_en = 1'b0;
    key_operator_i.tap(K_UP, 10);
    check("module", 17'h0_0001, 17'(cur_module));
    key_operator_i.tap(K_PAR, 10);
    check("param", 17'h0_0000, 17'(cur_param));
    key_operator_i.tap(K_DOWN, 10);
    check("edit", 17'h0_0007, edit_value);
    key_operator_i.tap(K_PAR, 10);
    check("param", 17'h0_0001, 17'(cur_param));
    key_operator_i.tap(K_PAR, 10);
    check("param", 17'h0_0002, 17'(cur_param));
    key_operator_i.hold(K_RST, 1'b1);
    key_operator_i.tap(K_UP, 10);
    key_operator_i.hold(K_RST, 1'b0);
    check("edit", 17'h0_03E8, edit_value);
    key_operator_i.tap(K_UP, 10);
    check("edit", 17'h0_03E9, edit_value);
    key_operator_i.tap(K_PAR, 10);
    key_operator_i.tap(K_UP, 100);
    check("repeat", 17'h0_0001, 17'(edit_value > 17'h0_0002));
    key_operator_i.tap(K_PAR, 10);
    check("module", 17'h0_0001, 17'(cur_module));
    check("prog", 17'h0_0001, 17'(prog_active));
    rd_index = 6'h04;
    settle(2);
    check("store", 17'h0_0007, rd_data);
    rd_index = 6'h06;
    settle(2);
    check("store", 17'h0_03E9, rd_data);
    repeat (5) key_operator_i.tap(K_UP, 10);
    check("module", 17'h0_0009, 17'(cur_module));
    key_operator_i.tap(K_DOWN, 10);
    check("module", 17'h0_0005, 17'(cur_module));
    card_present = 3'b001;
    key_operator_i.tap(K_UP, 10);
    check("module", 17'h0_0006, 17'(cur_module));
    key_operator_i.tap(K_UP, 10);
    check("module", 17'h0_0009, 17'(cur_module));
    key_operator_i.tap(K_PAR, 10);
    key_operator_i.tap(K_UP, 10);
    key_operator_i.tap(K_PAR, 10);
    check("restored", 17'h0_0001, 17'(n_restore));
    rd_index = 6'h04;
    settle(2);
    check("store", 17'h0_0000, rd_data);
    key_operator_i.tap(K_DSP, 10);
    check("prog", 17'h0_0000, 17'(prog_active));
    check("commit", 17'h0_0001, 17'(n_commit));
    quick_only = 1'b1;
    quick_mask = 40'h00_0000_0020;
    key_operator_i.tap(K_PAR, 10);
    check("quick", 17'h0_0001, 17'(quick_prog));
    check("full", 17'h0_0000, 17'(full_prog));
    key_operator_i.tap(K_UP, 10);
    key_operator_i.tap(K_PAR, 10);
    check("param", 17'h0_0001, 17'(cur_param));
    key_operator_i.tap(K_PAR, 10);
    check("module", 17'h0_0001, 17'(cur_module));
    key_operator_i.tap(K_DOWN, 10);
    key_operator_i.tap(K_PAR, 10);
    check("prog", 17'h0_0000, 17'(prog_active));
    check("commit", 17'h0_0002, 17'(n_commit));
    stop_test();
  end
endmodule
